// ==== frt_regs.svh ====
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH

// register indices; the apb byte address is four times the index
`define FRT_IDX_FR_LO 6'h20
`define FRT_IDX_FR_HI 6'h21
`define FRT_IDX_PIT_LO 6'h26
`define FRT_IDX_PIT_HI 6'h27
`define FRT_IDX_RL_LO 6'h28
`define FRT_IDX_RL_HI 6'h29
`define FRT_IDX_CTRL 6'h2a
`define FRT_IDX_STAT 6'h2b
`define FRT_IDX_MASK 6'h2c

// field positions
`define FRT_ST_TICK 0
`define FRT_ST_WRAP 1
`define FRT_ST_PIT 2
`define FRT_CTRL_FAST 0

// reset values
`define FRT_RST_COUNT 16'h0000
`define FRT_RST_PIT 12'h000
`define FRT_RST_BYTE 8'h00
`define FRT_RST_FLAGS 3'h0

// timing
`define FRT_TICK_US 1024
`define FRT_TB_SLOW_MHZ 4
`define FRT_TB_FAST_MHZ 6
`define FRT_COUNT_MAX 16'hffff

// wrap request routing toward the interrupt controller
`define FRT_WRAP_PRIO 5'h11
`define FRT_WRAP_VECTOR 16'h0044

`endif

// ==== frt_pkg.sv ====
package frt_pkg;

  typedef struct packed {
    logic tick;
    logic wrap;
    logic interval;
  } frt_events_t;

  typedef struct packed {
    logic tb_meta;
    logic tb_sync;
    logic tb_prev;
    logic [15:0] count;
    logic [7:0] fr_hold;
    logic [7:0] wr_low;
    logic [11:0] pit;
    logic [3:0] pit_hold;
    logic [11:0] reload;
    logic rate_fast;
    logic [12:0] tick_cnt;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] prdata;
    logic slverr;
    logic [15:0] snap;
    logic tick_p;
    logic wrap_p;
    logic pit_p;
  } frt_state_t;

endpackage : frt_pkg

// ==== frt_timer.sv ====
`timescale 1ns/1ps
`include "frt_regs.svh"

// Operation
// - 16-bit up counter advancing per timebase edge
// - low byte read captures high byte
// - tick request every 1024 us
// - wrap request on counter overflow
// - read sampled at low, write at high
// - read-only 12-bit interval count, nibble held
// - interval high: held nibble, upper zero
// - 12-bit reload, low byte then nibble
// - wrap request uses priority 17, vector 0044h
// - counters and reload reset to zero
// - timebase crossed safely into core clock
module frt_timer #(
  parameter int TICK_EDGES_SLOW = `FRT_TICK_US * `FRT_TB_SLOW_MHZ,
  parameter int TICK_EDGES_FAST = `FRT_TICK_US * `FRT_TB_FAST_MHZ
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tb_clk_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output frt_pkg::frt_events_t events,
  output logic [4:0] wrap_priority,
  output logic [15:0] wrap_vector,
  output logic irq
);

  localparam logic [12:0] LIM_SLOW = 13'(TICK_EDGES_SLOW - 1);
  localparam logic [12:0] LIM_FAST = 13'(TICK_EDGES_FAST - 1);

  frt_pkg::frt_state_t q;
  frt_pkg::frt_state_t d;

  logic tb_rise;
  logic setup;
  logic acc;
  logic acc_rd;
  logic acc_wr;
  logic [12:0] tick_lim;
  logic [2:0] clr;
  logic [2:0] set;

  function automatic logic frt_hit(input logic [7:0] addr, input logic [5:0] idx);
    frt_hit = (addr == {idx, 2'b00});
  endfunction : frt_hit

  function automatic logic frt_mapped(input logic [7:0] addr);
    frt_mapped = frt_hit(addr, `FRT_IDX_FR_LO) | frt_hit(addr, `FRT_IDX_FR_HI) |
                 frt_hit(addr, `FRT_IDX_PIT_LO) | frt_hit(addr, `FRT_IDX_PIT_HI) |
                 frt_hit(addr, `FRT_IDX_RL_LO) | frt_hit(addr, `FRT_IDX_RL_HI) |
                 frt_hit(addr, `FRT_IDX_CTRL) | frt_hit(addr, `FRT_IDX_STAT) |
                 frt_hit(addr, `FRT_IDX_MASK);
  endfunction : frt_mapped

  // only the synchronised copy is edge-detected, never the first stage
  assign tb_rise = q.tb_sync & ~q.tb_prev;
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign acc_rd = acc & ~pwrite;
  assign acc_wr = acc & pwrite;
  assign tick_lim = q.rate_fast ? LIM_FAST : LIM_SLOW;

  always_comb begin
    d = q;
    clr = `FRT_RST_FLAGS;
    set = `FRT_RST_FLAGS;
    d.tb_meta = tb_clk_in;
    d.tb_sync = q.tb_meta;
    d.tb_prev = q.tb_sync;
    d.tick_p = 1'b0;
    d.wrap_p = 1'b0;
    d.pit_p = 1'b0;

    if (tb_rise) begin
      d.count = q.count + 16'h0001;
      if (q.count == `FRT_COUNT_MAX) begin
        d.wrap_p = 1'b1;
      end
      // tick counter kept apart from the main count so it works at either rate
      if (q.tick_cnt >= tick_lim) begin
        d.tick_cnt = 13'h0000;
        d.tick_p = 1'b1;
      end else begin
        d.tick_cnt = q.tick_cnt + 13'h0001;
      end
      // zero reload parks the interval timer instead of firing every edge
      if (q.pit == `FRT_RST_PIT) begin
        if (q.reload != `FRT_RST_PIT) begin
          d.pit = q.reload;
          d.pit_p = 1'b1;
        end
      end else begin
        d.pit = q.pit - 12'h001;
      end
    end

    // read data and the value to hold are taken together in the setup cycle
    if (setup) begin
      d.slverr = ~frt_mapped(paddr);
      d.prdata = 32'h0000_0000;
      d.snap = q.count;
      if (frt_hit(paddr, `FRT_IDX_FR_LO)) begin
        d.prdata[7:0] = q.count[7:0];
      end
      if (frt_hit(paddr, `FRT_IDX_FR_HI)) begin
        d.prdata[7:0] = q.fr_hold;
      end
      if (frt_hit(paddr, `FRT_IDX_PIT_LO)) begin
        d.prdata[7:0] = q.pit[7:0];
        d.snap = {4'h0, q.pit};
      end
      if (frt_hit(paddr, `FRT_IDX_PIT_HI)) begin
        d.prdata[3:0] = q.pit_hold;
      end
      if (frt_hit(paddr, `FRT_IDX_RL_LO)) begin
        d.prdata[7:0] = q.reload[7:0];
      end
      if (frt_hit(paddr, `FRT_IDX_RL_HI)) begin
        d.prdata[3:0] = q.reload[11:8];
      end
      if (frt_hit(paddr, `FRT_IDX_CTRL)) begin
        d.prdata[`FRT_CTRL_FAST] = q.rate_fast;
      end
      if (frt_hit(paddr, `FRT_IDX_STAT)) begin
        d.prdata[2:0] = q.status;
      end
      if (frt_hit(paddr, `FRT_IDX_MASK)) begin
        d.prdata[2:0] = q.mask;
      end
    end

    // side effects of reads land only at the completing edge
    if (acc_rd && frt_hit(paddr, `FRT_IDX_FR_LO)) begin
      d.fr_hold = q.snap[15:8];
    end
    if (acc_rd && frt_hit(paddr, `FRT_IDX_PIT_LO)) begin
      d.pit_hold = q.snap[11:8];
    end

    if (acc_wr) begin
      if (frt_hit(paddr, `FRT_IDX_FR_LO)) begin
        d.wr_low = pwdata[7:0];
      end
      // a high-byte write beats a coincident timebase increment
      if (frt_hit(paddr, `FRT_IDX_FR_HI)) begin
        d.count = {pwdata[7:0], q.wr_low};
      end
      if (frt_hit(paddr, `FRT_IDX_RL_LO)) begin
        d.reload[7:0] = pwdata[7:0];
      end
      if (frt_hit(paddr, `FRT_IDX_RL_HI)) begin
        d.reload[11:8] = pwdata[3:0];
      end
      if (frt_hit(paddr, `FRT_IDX_CTRL)) begin
        d.rate_fast = pwdata[`FRT_CTRL_FAST];
      end
      if (frt_hit(paddr, `FRT_IDX_STAT)) begin
        clr = pwdata[2:0];
      end
      if (frt_hit(paddr, `FRT_IDX_MASK)) begin
        d.mask = pwdata[2:0];
      end
    end

    set[`FRT_ST_TICK] = d.tick_p;
    set[`FRT_ST_WRAP] = d.wrap_p;
    set[`FRT_ST_PIT] = d.pit_p;
    // set wins over a write-one clear in the same cycle
    d.status = (q.status & ~clr) | set;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // zero-wait slave: data was registered during setup
  assign pready = acc;
  assign pslverr = acc & q.slverr;
  assign prdata = q.prdata;
  // one driver for the whole struct, field order tick, wrap, interval
  assign events = {q.tick_p, q.wrap_p, q.pit_p};
  assign wrap_priority = `FRT_WRAP_PRIO;
  assign wrap_vector = `FRT_WRAP_VECTOR;
  assign irq = |(q.status & q.mask);

  logic fr_hi_wr;
  assign fr_hi_wr = acc_wr & frt_hit(paddr, `FRT_IDX_FR_HI);
  logic tick_due;
  assign tick_due = tb_rise & (q.tick_cnt >= tick_lim);

  sequence s_lo_setup;
    setup && !pwrite && frt_hit(paddr, `FRT_IDX_FR_LO);
  endsequence

  sequence s_lo_access;
    acc_rd && frt_hit(paddr, `FRT_IDX_FR_LO);
  endsequence

  sequence s_pit_lo_setup;
    setup && !pwrite && frt_hit(paddr, `FRT_IDX_PIT_LO);
  endsequence

  sequence s_pit_lo_access;
    acc_rd && frt_hit(paddr, `FRT_IDX_PIT_LO);
  endsequence

  a_count_advance: assert property (@(posedge core_clk) disable iff (reset)
    tb_rise && !fr_hi_wr |=> q.count == $past(q.count) + 16'h0001)
    else $error("counter did not advance on timebase edge");

  a_atomic_read: assert property (@(posedge core_clk) disable iff (reset)
    s_lo_setup ##1 s_lo_access |=> q.fr_hold == $past(q.count[15:8], 2))
    else $error("high byte not held from low byte read");

  a_wrap_event: assert property (@(posedge core_clk) disable iff (reset)
    tb_rise && q.count == `FRT_COUNT_MAX && !fr_hi_wr |=> q.count == 16'h0000 && events.wrap)
    else $error("wrap not signalled on overflow");

  a_count_write: assert property (@(posedge core_clk) disable iff (reset)
    fr_hi_wr |=> q.count == {$past(pwdata[7:0]), $past(q.wr_low)})
    else $error("counter write did not transfer both bytes");

  a_pit_high_read: assert property (@(posedge core_clk) disable iff (reset)
    setup && !pwrite && frt_hit(paddr, `FRT_IDX_PIT_HI) |=> prdata[7:4] == 4'h0 && prdata[3:0] == $past(q.pit_hold))
    else $error("interval high read wrong");

  a_pit_reload: assert property (@(posedge core_clk) disable iff (reset)
    tb_rise && q.pit == 12'h000 && q.reload != 12'h000 |=> q.pit == $past(q.reload) && events.interval)
    else $error("interval timer did not reload");

  a_reset_zero: assert property (@(posedge core_clk) disable iff (reset)
    $past(reset) |-> q.count == 16'h0000 && q.pit == 12'h000 && q.reload == 12'h000)
    else $error("state not zero after reset");

  a_tick_single: assert property (@(posedge core_clk) disable iff (reset)
    events.tick |=> !events.tick ##1 !events.tick)
    else $error("tick request longer than one cycle");

  a_tick_sticky: assert property (@(posedge core_clk) disable iff (reset)
    events.tick |-> q.status[`FRT_ST_TICK])
    else $error("tick event did not set status");

  a_wrap_route: assert property (@(posedge core_clk) disable iff (reset)
    events.wrap |-> wrap_priority == 5'h11 && wrap_vector == 16'h0044)
    else $error("wrap routing wrong");

  a_fr_low_data: assert property (@(posedge core_clk) disable iff (reset)
    s_lo_setup |=> prdata == {24'h000000, $past(q.count[7:0])})
    else $error("low byte read data wrong");

  a_fr_high_data: assert property (@(posedge core_clk) disable iff (reset)
    setup && !pwrite && frt_hit(paddr, `FRT_IDX_FR_HI) |=> prdata == {24'h000000, $past(q.fr_hold)})
    else $error("high byte read did not return held byte");

  a_hold_steady: assert property (@(posedge core_clk) disable iff (reset)
    !(acc_rd && frt_hit(paddr, `FRT_IDX_FR_LO)) |=> $stable(q.fr_hold))
    else $error("high byte hold changed without low byte read");

  a_count_hold: assert property (@(posedge core_clk) disable iff (reset)
    !tb_rise && !fr_hi_wr |=> $stable(q.count))
    else $error("counter moved without timebase edge or write");

  a_low_write_held: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && frt_hit(paddr, `FRT_IDX_FR_LO) && !tb_rise |=> $stable(q.count) && q.wr_low == $past(pwdata[7:0]))
    else $error("low byte write reached the counter early");

  a_tick_period: assert property (@(posedge core_clk) disable iff (reset)
    tick_due |=> events.tick && q.tick_cnt == 13'h0000)
    else $error("tick not raised at end of period");

  a_tick_only_due: assert property (@(posedge core_clk) disable iff (reset)
    !tick_due |=> !events.tick)
    else $error("tick raised before period elapsed");

  a_wrap_only_max: assert property (@(posedge core_clk) disable iff (reset)
    !(tb_rise && q.count == `FRT_COUNT_MAX) |=> !events.wrap)
    else $error("wrap raised without overflow");

  a_wrap_sticky: assert property (@(posedge core_clk) disable iff (reset)
    events.wrap |-> q.status[`FRT_ST_WRAP])
    else $error("wrap event did not set status");

  a_status_clear: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && frt_hit(paddr, `FRT_IDX_STAT) && pwdata[`FRT_ST_WRAP] |=> !q.status[`FRT_ST_WRAP] || events.wrap)
    else $error("wrap status not cleared by write of one");

  a_wrap_single: assert property (@(posedge core_clk) disable iff (reset)
    events.wrap |=> !events.wrap)
    else $error("wrap request longer than one cycle");

  a_pit_single: assert property (@(posedge core_clk) disable iff (reset)
    events.interval |=> !events.interval)
    else $error("interval request longer than one cycle");

  a_sync_latency: assert property (@(posedge core_clk) disable iff (reset)
    $rose(tb_clk_in) |-> ##2 tb_rise)
    else $error("timebase edge not seen after two flops");

  a_pit_hold_read: assert property (@(posedge core_clk) disable iff (reset)
    s_pit_lo_setup ##1 s_pit_lo_access |=> q.pit_hold == $past(q.pit[11:8], 2))
    else $error("interval nibble not held from low byte read");

  a_pit_low_data: assert property (@(posedge core_clk) disable iff (reset)
    s_pit_lo_setup |=> prdata == {24'h000000, $past(q.pit[7:0])})
    else $error("interval low read data wrong");

  a_pit_read_only: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && (frt_hit(paddr, `FRT_IDX_PIT_LO) || frt_hit(paddr, `FRT_IDX_PIT_HI)) && !tb_rise |=> $stable(q.pit))
    else $error("interval count changed by a write");

  a_pit_hold_steady: assert property (@(posedge core_clk) disable iff (reset)
    !(acc_rd && frt_hit(paddr, `FRT_IDX_PIT_LO)) |=> $stable(q.pit_hold))
    else $error("interval nibble changed without low byte read");

  a_pit_countdown: assert property (@(posedge core_clk) disable iff (reset)
    tb_rise && q.pit != 12'h000 |=> q.pit == $past(q.pit) - 12'h001 && !events.interval)
    else $error("interval timer did not count down");

  a_pit_parked: assert property (@(posedge core_clk) disable iff (reset)
    tb_rise && q.pit == 12'h000 && q.reload == 12'h000 |=> q.pit == 12'h000 && !events.interval)
    else $error("parked interval timer moved");

  a_pit_reload_only: assert property (@(posedge core_clk) disable iff (reset)
    !(tb_rise && q.pit == 12'h000 && q.reload != 12'h000) |=> !events.interval)
    else $error("interval request without terminal count");

  a_reload_low_write: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && frt_hit(paddr, `FRT_IDX_RL_LO) |=> q.reload[7:0] == $past(pwdata[7:0]))
    else $error("reload low byte not written");

  a_reload_high_write: assert property (@(posedge core_clk) disable iff (reset)
    acc_wr && frt_hit(paddr, `FRT_IDX_RL_HI) |=> q.reload[11:8] == $past(pwdata[3:0]))
    else $error("reload high nibble not written");

endmodule : frt_timer

// ==== frt_timer_tb.sv ====
`timescale 1ns/1ps
`include "frt_regs.svh"

module free_running_and_interval_timer_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic tb_clk_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  frt_pkg::frt_events_t events;
  logic [4:0] wrap_priority;
  logic [15:0] wrap_vector;
  logic irq;
  int fail_count = 0;
  int checks_done = 0;
  int tick_seen = 0;
  int wrap_seen = 0;
  int pit_seen = 0;
  logic [2:0] ev_q = 3'h0;
  logic [31:0] rd;
  logic err;

  frt_timer #(.TICK_EDGES_SLOW(8), .TICK_EDGES_FAST(12)) frt_timer_inst (
    .core_clk(core_clk), .reset(reset), .tb_clk_in(tb_clk_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .wrap_priority(wrap_priority), .wrap_vector(wrap_vector),
    .irq(irq));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // each event counted once; a two-cycle pulse would be a fault
  always @(posedge core_clk) begin
    if (events.tick === 1'b1) tick_seen++;
    if (events.wrap === 1'b1) wrap_seen++;
    if (events.interval === 1'b1) pit_seen++;
    if (!reset) check({29'h0, events & ev_q}, 32'h0);
    ev_q <= events;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // n timebase periods, each phase long enough to be synchronised
  task automatic tb_edges(input int n);
    repeat (n) begin
      @(posedge core_clk) tb_clk_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      tb_clk_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : tb_edges

  task automatic t_reset_values();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 6'((i < 2) ? 32'h20 + i : 32'h24 + i), 32'h0);
      check(rd, 32'h0);
    end
    check({27'h0, wrap_priority}, 32'd17);
    check({16'h0, wrap_vector}, 32'h0044);
    apb(1'b0, 6'h3f, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_reset_values

  task automatic t_free_count();
    int w;
    apb(1'b1, `FRT_IDX_FR_LO, 32'hff);
    apb(1'b0, `FRT_IDX_FR_LO, 32'h0);
    check(rd, 32'h00);
    apb(1'b1, `FRT_IDX_FR_HI, 32'h01);
    apb(1'b0, `FRT_IDX_FR_LO, 32'h0);
    check(rd, 32'hff);
    tb_edges(1);
    apb(1'b0, `FRT_IDX_FR_HI, 32'h0);
    check(rd, 32'h01);
    apb(1'b0, `FRT_IDX_FR_LO, 32'h0);
    check(rd, 32'h00);
    apb(1'b0, `FRT_IDX_FR_HI, 32'h0);
    check(rd, 32'h02);
    apb(1'b1, `FRT_IDX_FR_LO, 32'hfe);
    apb(1'b1, `FRT_IDX_FR_HI, 32'hff);
    w = wrap_seen;
    tb_edges(1);
    check(wrap_seen - w, 32'd0);
    tb_edges(1);
    check(wrap_seen - w, 32'd1);
    apb(1'b0, `FRT_IDX_FR_LO, 32'h0);
    check(rd, 32'h00);
  endtask : t_free_count

  task automatic t_irq_mask();
    apb(1'b1, `FRT_IDX_MASK, 32'h0);
    apb(1'b0, `FRT_IDX_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `FRT_IDX_MASK, 32'h1 << `FRT_ST_WRAP);
    // the mask lands on the edge the task returns at; look once it has settled
    @(negedge core_clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `FRT_IDX_STAT, 32'h1 << `FRT_ST_WRAP);
    apb(1'b0, `FRT_IDX_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : t_irq_mask

  task automatic t_tick_rate(input logic fast, input int exp);
    int n;
    int t;
    apb(1'b1, `FRT_IDX_CTRL, {31'h0, fast});
    t = tick_seen;
    n = 0;
    while (tick_seen == t && n < 20) begin
      tb_edges(1);
      n++;
    end
    t = tick_seen;
    n = 0;
    while (tick_seen == t && n < 20) begin
      tb_edges(1);
      n++;
    end
    check(n, exp);
  endtask : t_tick_rate

  task automatic t_interval();
    int p;
    apb(1'b1, `FRT_IDX_RL_LO, 32'h03);
    apb(1'b1, `FRT_IDX_RL_HI, 32'h01);
    apb(1'b0, `FRT_IDX_RL_HI, 32'h0);
    check(rd, 32'h01);
    p = pit_seen;
    tb_edges(3);
    check({31'h0, pit_seen > p}, 32'h1);
    apb(1'b1, `FRT_IDX_PIT_LO, 32'hff);
    apb(1'b0, `FRT_IDX_PIT_LO, 32'h0);
    check(rd, 32'h01);
    tb_edges(4);
    apb(1'b0, `FRT_IDX_PIT_HI, 32'h0);
    check(rd, 32'h01);
    apb(1'b1, `FRT_IDX_RL_LO, 32'h02);
    apb(1'b1, `FRT_IDX_RL_HI, 32'h00);
    tb_edges(260);
    p = pit_seen;
    tb_edges(9);
    check({31'h0, pit_seen - p >= 2}, 32'h1);
  endtask : t_interval

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_values();
    t_free_count();
    t_irq_mask();
    t_tick_rate(1'b0, 8);
    t_tick_rate(1'b1, 12);
    t_interval();
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end
endmodule : free_running_and_interval_timer_tb
